/* inc/spi_cmd_defs.svh */
`ifndef SPI_CMD_DEFS_SVH
`define SPI_CMD_DEFS_SVH

// ---------------------------------------------------------------
// Word format
// ---------------------------------------------------------------
`define WORD_BITS 16
`define EDGE_CNT_W 8
`define MSG_INVALID_BIT 15
`define MSG_INVALID_MASK 15'h4000
`define ANS_RST_WORD 16'h0001

// ---------------------------------------------------------------
// Request words and field patterns
// ---------------------------------------------------------------
`define CMD_ENTER_CONFIG 16'h1880
`define CMD_ENTER_VERIFY 16'h1140
`define CMD_LEAVE_CONFIG 16'h1220
`define CMD_NOP 16'h1410
`define READ_HDR 4'h0
`define READ_TAIL 6'h15
`define WRH_HDR 7'h22
`define WRL_HDR 4'ha

`endif

/* inc/spi_cmd_pkg.sv */
`include "spi_cmd_defs.svh"

package spi_cmd_pkg;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      default_mode,
      error_mode,
      configuration_mode,
      configured_mode,
      active_mode,
      verification_mode,
      weak_active_mode
   } opm_t;

   typedef enum logic [1:0] {st_idle, st_xfer, st_eval, st_fetch} core_st_t;

   typedef enum logic [1:0] {ans_status, ans_status_inv, ans_reg} ans_sel_t;

   typedef struct packed {
      logic req;
      logic [4:0] addr;
   } reg_read_t;

   typedef struct packed {
      logic req;
      logic [4:0] addr;
      logic [15:0] data;
   } reg_write_t;

   typedef struct packed {
      logic req;
      opm_t target;
   } mode_req_t;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic odd_par(input logic [14:0] pay);
      return ~^pay;
   endfunction

   function automatic logic [`EDGE_CNT_W-1:0] to_gray(input logic [`EDGE_CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [`EDGE_CNT_W-1:0] from_gray(input logic [`EDGE_CNT_W-1:0] g);
      logic [`EDGE_CNT_W-1:0] b;
      b = g;
      for (int i = `EDGE_CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

/* hw/spi_command_slave.sv */
`timescale 1ns/1ns
`include "spi_cmd_defs.svh"

// Notes on behaviour
// - Chip select level accepted only after two equal consecutive core-clock samples.
// - Every serial word is sixteen bits.
// - A transfer lasts from chip select falling to the next rising edge.
// - Daisy chain: words pass through, our answer leads, last word is ours.
// - Answer to a request is shifted out during the following transfer.
// - First word after power-up is the primary status value.
// - Bit 0 of every word is odd parity over fifteen payload bits.
// - With parity check disabled, received parity bit is ignored except in fixed-value commands.
// - Transmitted words always carry correct parity.
// - Fixed-value commands with wrong parity always raise an SPI error.
// - On SPI error: discard request, set error flag, answer with last_message_invalid set.
// - Errors: parity, bad length, unknown word, wrong mode, busy read, bad address.
// - An answer with last_message_invalid set otherwise carries the primary status value.
// - Enter-config 1880h only from default or error mode, else error.
// - Enter-verify 1140h only from configuration mode, else error.
// - Leave-config 1220h only from configuration mode, else error.
// - Read request layout; accepted in every mode, answers register value.
// - Write-high loads upper write-buffer byte only; accepted in every mode.
// - Write-low loads bits 7:2 of the low byte (bits 1:0 zero), writes buffer to register, clears buffer.
// - At chip select release, unequal or non-multiple-of-16 edge counts are errors.
// - Shift out on clock rise MSB first, capture on fall, tristate when idle.
// - NOP 1410h does nothing, valid in every mode, answered with status.

module spi_command_slave (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic ncs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic parity_check_enable,
   input wire logic [14:0] primary_status_register,
   input wire spi_cmd_pkg::opm_t mode,
   input wire logic [31:0] read_addr_map,
   input wire logic [31:0] write_addr_map,
   input wire logic rd_busy,
   input wire logic [14:0] rd_data,
   output spi_cmd_pkg::reg_read_t rd_req,
   output spi_cmd_pkg::reg_write_t wr_req,
   output spi_cmd_pkg::mode_req_t mode_req,
   output logic spi_error,
   output logic spi_error_flag,
   input wire logic spi_error_clr
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic link_clr_ff;
   logic [`EDGE_CNT_W-1:0] rise_bin_ff, rise_gray_ff, fall_bin_ff, fall_gray_ff;
   logic [`EDGE_CNT_W-1:0] nxt_rise_bin, nxt_fall_bin;
   logic [4:0] tx_pos_ff;
   logic sdo_ff;
   logic [15:0] rx_sh_ff;
   logic ncs_meta_ff, ncs_s2_ff, cs_smp_ff, cs_act_ff;
   logic [`EDGE_CNT_W-1:0] rise_meta_ff, rise_s2_ff, fall_meta_ff, fall_s2_ff;
   logic [`EDGE_CNT_W-1:0] base_rise_ff, base_fall_ff, rise_cnt, fall_cnt;
   logic [15:0] rx_meta_ff, rx_s2_ff, word;
   spi_cmd_pkg::core_st_t st_ff;
   spi_cmd_pkg::ans_sel_t ans_sel_ff;
   logic [15:0] ans_word_ff;
   logic [7:0] wbuf_hi_ff;
   logic [4:0] addr;
   logic eval, len_err, par_err, is_fixed, is_read, is_wrh, is_wrl, cmd_ok, cmd_err, mode_chg;
   spi_cmd_pkg::opm_t tgt;
   spi_cmd_pkg::reg_read_t rd_req_ff;
   spi_cmd_pkg::reg_write_t wr_req_ff;
   spi_cmd_pkg::mode_req_t mode_req_ff;
   logic err_pulse_ff, spi_error_flag_ff;

   // ---------------------------------------------------------------
   // Link side (serial clock domain)
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      link_clr_ff <= rst;
   end

   assign nxt_rise_bin = rise_bin_ff + `EDGE_CNT_W'(1);
   assign nxt_fall_bin = fall_bin_ff + `EDGE_CNT_W'(1);

   // Free-running edge counters, handed over in gray code
   always_ff @(posedge sclk or posedge link_clr_ff) begin
      if (link_clr_ff) begin
         rise_bin_ff <= '0;
         rise_gray_ff <= '0;
      end else if (!ncs_n) begin
         rise_bin_ff <= nxt_rise_bin;
         rise_gray_ff <= spi_cmd_pkg::to_gray(nxt_rise_bin);
      end
   end

   always_ff @(negedge sclk or posedge link_clr_ff) begin
      if (link_clr_ff) begin
         fall_bin_ff <= '0;
         fall_gray_ff <= '0;
      end else if (!ncs_n) begin
         fall_bin_ff <= nxt_fall_bin;
         fall_gray_ff <= spi_cmd_pkg::to_gray(nxt_fall_bin);
      end
   end

   // Capture on falling edges
   always_ff @(negedge sclk) begin
      if (!ncs_n) begin
         rx_sh_ff <= {rx_sh_ff[14:0], sdi};
      end
   end

   // Answer word first, then pass received bits through to the chain
   always_ff @(posedge sclk or posedge ncs_n or posedge link_clr_ff) begin
      if (ncs_n || link_clr_ff) begin
         tx_pos_ff <= '0;
         sdo_ff <= 1'b0;
      end else begin
         if (!tx_pos_ff[4]) begin
            tx_pos_ff <= tx_pos_ff + 5'h01;
         end
         sdo_ff <= tx_pos_ff[4] ? rx_sh_ff[15] : ans_word_ff[4'hf - tx_pos_ff[3:0]];
      end
   end

   assign sdo = sdo_ff;
   assign sdo_oe = !ncs_n;

   // ---------------------------------------------------------------
   // Crossing into the core clock domain
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ncs_meta_ff <= 1'b1;
         ncs_s2_ff <= 1'b1;
      end else begin
         ncs_meta_ff <= ncs_n;
         ncs_s2_ff <= ncs_meta_ff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rise_meta_ff <= '0;
         rise_s2_ff <= '0;
         fall_meta_ff <= '0;
         fall_s2_ff <= '0;
      end else begin
         rise_meta_ff <= rise_gray_ff;
         rise_s2_ff <= rise_meta_ff;
         fall_meta_ff <= fall_gray_ff;
         fall_s2_ff <= fall_meta_ff;
      end
   end

   // Received word is quiet while chip select is high
   always_ff @(posedge core_clk) begin
      rx_meta_ff <= rx_sh_ff;
      rx_s2_ff <= rx_meta_ff;
   end

   // ---------------------------------------------------------------
   // Chip select filter
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_smp_ff <= 1'b1;
         cs_act_ff <= 1'b0;
      end else begin
         cs_smp_ff <= ncs_s2_ff;
         if (ncs_s2_ff == cs_smp_ff) begin
            cs_act_ff <= !ncs_s2_ff;
         end
      end
   end

   chk_cs_filter: assert property (@(posedge core_clk) disable iff (rst)
      (cs_act_ff != $past(cs_act_ff)) |-> ($past(ncs_s2_ff) == $past(ncs_s2_ff, 2)) && (cs_act_ff == !$past(ncs_s2_ff)))
      else $error("chip select accepted without two equal samples");

   // ---------------------------------------------------------------
   // Transfer sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= spi_cmd_pkg::st_idle;
      end else begin
         unique case (st_ff)
            spi_cmd_pkg::st_idle: begin
               if (cs_act_ff) begin
                  st_ff <= spi_cmd_pkg::st_xfer;
               end
            end
            spi_cmd_pkg::st_xfer: begin
               if (!cs_act_ff) begin
                  st_ff <= spi_cmd_pkg::st_eval;
               end
            end
            spi_cmd_pkg::st_eval: begin
               st_ff <= (is_read && !cmd_err) ? spi_cmd_pkg::st_fetch : spi_cmd_pkg::st_idle;
            end
            spi_cmd_pkg::st_fetch: begin
               st_ff <= spi_cmd_pkg::st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         base_rise_ff <= '0;
         base_fall_ff <= '0;
      end else if (st_ff == spi_cmd_pkg::st_idle && cs_act_ff) begin
         base_rise_ff <= spi_cmd_pkg::from_gray(rise_s2_ff);
         base_fall_ff <= spi_cmd_pkg::from_gray(fall_s2_ff);
      end
   end

   // ---------------------------------------------------------------
   // Word checks and decode
   // ---------------------------------------------------------------
   assign eval = (st_ff == spi_cmd_pkg::st_eval);
   assign rise_cnt = spi_cmd_pkg::from_gray(rise_s2_ff) - base_rise_ff;
   assign fall_cnt = spi_cmd_pkg::from_gray(fall_s2_ff) - base_fall_ff;
   assign len_err = (rise_cnt != fall_cnt) || (rise_cnt[3:0] != 4'h0) || (rise_cnt == '0);
   assign word = rx_s2_ff;
   assign addr = word[11:7];
   assign is_fixed = (word == `CMD_ENTER_CONFIG) || (word == `CMD_ENTER_VERIFY) ||
                     (word == `CMD_LEAVE_CONFIG) || (word == `CMD_NOP);
   assign is_read = (word[15:12] == `READ_HDR) && (word[6:1] == `READ_TAIL);
   assign is_wrh = (word[15:9] == `WRH_HDR);
   assign is_wrl = (word[15:12] == `WRL_HDR);
   assign par_err = !is_fixed && parity_check_enable && !(^word);

   always_comb begin
      cmd_ok = 1'b0;
      mode_chg = 1'b0;
      tgt = spi_cmd_pkg::default_mode;
      if (word == `CMD_ENTER_CONFIG) begin
         cmd_ok = (mode == spi_cmd_pkg::default_mode) || (mode == spi_cmd_pkg::error_mode);
         mode_chg = 1'b1;
         tgt = spi_cmd_pkg::configuration_mode;
      end else if (word == `CMD_ENTER_VERIFY) begin
         cmd_ok = (mode == spi_cmd_pkg::configuration_mode);
         mode_chg = 1'b1;
         tgt = spi_cmd_pkg::verification_mode;
      end else if (word == `CMD_LEAVE_CONFIG) begin
         cmd_ok = (mode == spi_cmd_pkg::configuration_mode);
         mode_chg = 1'b1;
         tgt = spi_cmd_pkg::configured_mode;
      end else if (word == `CMD_NOP) begin
         cmd_ok = 1'b1;
      end else if (is_read) begin
         cmd_ok = read_addr_map[addr] && !rd_busy;
      end else if (is_wrh) begin
         cmd_ok = 1'b1;
      end else if (is_wrl) begin
         cmd_ok = write_addr_map[addr];
      end
   end

   assign cmd_err = len_err || par_err || !cmd_ok;

   // ---------------------------------------------------------------
   // Actions toward the rest of the device
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_req_ff <= '0;
      end else begin
         mode_req_ff.req <= eval && !cmd_err && mode_chg;
         mode_req_ff.target <= tgt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_req_ff <= '0;
      end else begin
         rd_req_ff.req <= eval && !cmd_err && is_read;
         if (eval) begin
            rd_req_ff.addr <= addr;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_req_ff <= '0;
         wbuf_hi_ff <= 8'h00;
      end else begin
         wr_req_ff.req <= eval && !cmd_err && is_wrl;
         if (eval && !cmd_err && is_wrh) begin
            wbuf_hi_ff <= word[8:1];
         end else if (eval && !cmd_err && is_wrl) begin
            wr_req_ff.addr <= addr;
            wr_req_ff.data <= {wbuf_hi_ff, word[6:1], 2'b00};
            wbuf_hi_ff <= 8'h00;
         end
      end
   end

   // Error flag: a new error wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         err_pulse_ff <= 1'b0;
         spi_error_flag_ff <= 1'b0;
      end else begin
         err_pulse_ff <= eval && cmd_err;
         spi_error_flag_ff <= (eval && cmd_err) || (spi_error_flag_ff && !spi_error_clr);
      end
   end

   assign rd_req = rd_req_ff;
   assign wr_req = wr_req_ff;
   assign mode_req = mode_req_ff;
   assign spi_error = err_pulse_ff;
   assign spi_error_flag = spi_error_flag_ff;

   // ---------------------------------------------------------------
   // Answer word for the next transfer
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ans_sel_ff <= spi_cmd_pkg::ans_status;
         ans_word_ff <= `ANS_RST_WORD;
      end else if (eval) begin
         if (cmd_err) begin
            ans_sel_ff <= spi_cmd_pkg::ans_status_inv;
            ans_word_ff <= {primary_status_register | `MSG_INVALID_MASK,
                            spi_cmd_pkg::odd_par(primary_status_register | `MSG_INVALID_MASK)};
         end else if (is_read) begin
            ans_sel_ff <= spi_cmd_pkg::ans_reg;
         end else begin
            ans_sel_ff <= spi_cmd_pkg::ans_status;
            ans_word_ff <= {primary_status_register, spi_cmd_pkg::odd_par(primary_status_register)};
         end
      end else if (st_ff == spi_cmd_pkg::st_fetch) begin
         ans_word_ff <= {rd_data, spi_cmd_pkg::odd_par(rd_data)};
      end else if (st_ff == spi_cmd_pkg::st_idle && ncs_s2_ff && ans_sel_ff != spi_cmd_pkg::ans_reg) begin
         if (ans_sel_ff == spi_cmd_pkg::ans_status_inv) begin
            ans_word_ff <= {primary_status_register | `MSG_INVALID_MASK,
                            spi_cmd_pkg::odd_par(primary_status_register | `MSG_INVALID_MASK)};
         end else begin
            ans_word_ff <= {primary_status_register, spi_cmd_pkg::odd_par(primary_status_register)};
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_tx_parity_odd: assert property (@(posedge core_clk) disable iff (rst)
      ^ans_word_ff == 1'b1)
      else $error("answer word parity not odd");

   chk_len_count_err: assert property (@(posedge core_clk) disable iff (rst)
      (eval && len_err) |=> err_pulse_ff && !mode_req_ff.req && !wr_req_ff.req && !rd_req_ff.req)
      else $error("bad edge count not reported");

   chk_enter_cfg_ok: assert property (@(posedge core_clk) disable iff (rst)
      (eval && word == `CMD_ENTER_CONFIG && !len_err &&
       (mode == spi_cmd_pkg::default_mode || mode == spi_cmd_pkg::error_mode))
      |=> mode_req_ff.req && mode_req_ff.target == spi_cmd_pkg::configuration_mode && !err_pulse_ff)
      else $error("enter config not requested");

   chk_enter_cfg_bad: assert property (@(posedge core_clk) disable iff (rst)
      (eval && word == `CMD_ENTER_CONFIG &&
       !(mode == spi_cmd_pkg::default_mode || mode == spi_cmd_pkg::error_mode))
      |=> err_pulse_ff && !mode_req_ff.req)
      else $error("enter config accepted in wrong mode");

   chk_verify_mode: assert property (@(posedge core_clk) disable iff (rst)
      (eval && word == `CMD_ENTER_VERIFY && !len_err)
      |=> (mode_req_ff.req == ($past(mode) == spi_cmd_pkg::configuration_mode)) &&
          (err_pulse_ff == !mode_req_ff.req))
      else $error("enter verify gated wrongly");

   chk_leave_cfg: assert property (@(posedge core_clk) disable iff (rst)
      (eval && word == `CMD_LEAVE_CONFIG && !len_err && mode == spi_cmd_pkg::configuration_mode)
      |=> mode_req_ff.req && mode_req_ff.target == spi_cmd_pkg::configured_mode)
      else $error("leave config not requested");

   chk_fixed_parity: assert property (@(posedge core_clk) disable iff (rst)
      (eval && (word ^ 16'h0001) == `CMD_NOP) |=> err_pulse_ff)
      else $error("fixed command with bad parity accepted");

   chk_parity_ignored: assert property (@(posedge core_clk) disable iff (rst)
      (eval && !parity_check_enable && is_read && !len_err && read_addr_map[addr] && !rd_busy)
      |=> !err_pulse_ff && rd_req_ff.req ##1 ans_sel_ff == spi_cmd_pkg::ans_reg)
      else $error("read refused with parity check off");

   chk_error_answer: assert property (@(posedge core_clk) disable iff (rst)
      err_pulse_ff |-> spi_error_flag_ff && ans_word_ff[`MSG_INVALID_BIT] &&
                       ans_word_ff[15:1] == ($past(primary_status_register) | `MSG_INVALID_MASK))
      else $error("error answer or flag missing");

   chk_wrl_clear: assert property (@(posedge core_clk) disable iff (rst)
      (eval && !cmd_err && is_wrl)
      |=> wr_req_ff.req && wbuf_hi_ff == 8'h00 && wr_req_ff.data[15:8] == $past(wbuf_hi_ff))
      else $error("write low did not flush buffer");

endmodule

/* dv/spi_master_model.sv */
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Serial master on the far side, link clock 48 ns
// ---------------------------------------------------------------
module spi_master_model (
   output logic sclk,
   output logic ncs_n,
   output logic sdi,
   input wire logic sdo,
   output logic done,
   output logic [31:0] rx
);
   initial begin
      sclk = 1'b0;
      ncs_n = 1'b1;
      sdi = 1'b0;
      done = 1'b0;
      rx = 32'h0;
   end

   // Sends the low n bits of w MSB first, one word per chained device
   task automatic xfer(input logic [31:0] w, input int n);
      rx = 32'h0;
      #7 ncs_n = 1'b0;
      #170;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         #2 sdi = w[i];
         #22 sclk = 1'b0;
         rx = {rx[30:0], sdo};
         #24;
      end
      sdi = ~sdi;
      #30 ncs_n = 1'b1;
      done = 1'b1;
      #20 done = 1'b0;
      #400;
   endtask

   // Chip select pulse without clock edges
   task automatic blip(input int t);
      ncs_n = 1'b0;
      #t ncs_n = 1'b1;
      #400;
   endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ns
`include "spi_cmd_defs.svh"

module tb;
   logic core_clk, rst, sclk, ncs_n, sdi, sdo, sdo_oe, pce, rd_busy, err, err_flag, err_clr, done;
   logic [14:0] psr, rd_data;
   logic [31:0] rmap, wmap, rx;
   logic [15:0] ans, d;
   logic [4:0] ra, bad;
   spi_cmd_pkg::opm_t mode, tgt;
   spi_cmd_pkg::reg_read_t rd_req;
   spi_cmd_pkg::reg_write_t wr_req;
   spi_cmd_pkg::mode_req_t mode_req;
   logic [31:0] exp_q[$];
   int bad_count, tests_run, n_err, n_mode, n_wr, n_rd, cyc;

   assign rd_data = {10'h2a5, rd_req.addr};

   spi_command_slave dut_u (.core_clk(core_clk), .rst(rst), .sclk(sclk), .ncs_n(ncs_n), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe), .parity_check_enable(pce), .primary_status_register(psr),
      .mode(mode), .read_addr_map(rmap), .write_addr_map(wmap), .rd_busy(rd_busy),
      .rd_data(rd_data), .rd_req(rd_req), .wr_req(wr_req), .mode_req(mode_req),
      .spi_error(err), .spi_error_flag(err_flag), .spi_error_clr(err_clr));

   spi_master_model m_u (.sclk(sclk), .ncs_n(ncs_n), .sdi(sdi), .sdo(sdo), .done(done), .rx(rx));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] mk(input logic [14:0] p);
      return {p, ~^p};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic run(input spi_cmd_pkg::opm_t m, input logic [31:0] w, input int n, input logic e,
      input logic r);
      int e0;
      @(posedge core_clk) #2;
      mode = m;
      e0 = n_err;
      exp_q.push_back({ans, w[31:16]} >> (32 - n));
      m_u.xfer(w, n);
      check(n_err - e0, {31'h0, e});
      ans = mk(e ? (psr | `MSG_INVALID_MASK) : (r ? {10'h2a5, w[11:7]} : psr));
   endtask

   // ---------------------------------------------------------------
   // Clock, monitors and timeout
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   always @(posedge done) begin
      check(rx, exp_q.pop_front());
   end

   always @(ncs_n) begin
      #1 check(sdo_oe, {31'h0, !ncs_n});
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (err === 1'b1) n_err <= n_err + 1;
      if (wr_req.req === 1'b1) n_wr <= n_wr + 1;
      if (rd_req.req === 1'b1) n_rd <= n_rd + 1;
      if (mode_req.req === 1'b1) begin
         n_mode <= n_mode + 1;
         tgt <= mode_req.target;
      end
      if (cyc == 8000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'hbff45ed8));
      {rst, pce, rd_busy, err_clr, cyc} = {1'b1, 1'b1, 1'b0, 1'b0, 32'h0};
      psr = 15'($urandom) & 15'h3fff;
      ra = 5'($urandom);
      bad = ra ^ 5'h10;
      d = 16'($urandom);
      rmap = ~(32'h1 << bad);
      wmap = rmap;
      mode = spi_cmd_pkg::default_mode;
      ans = mk(psr);
      repeat (16) @(posedge core_clk);
      #2 rst = 1'b0;
      repeat (5) @(posedge core_clk);
      check(err_flag, 0);
      run(spi_cmd_pkg::default_mode, 16'h1880, 16, 0, 0);
      check(tgt, spi_cmd_pkg::configuration_mode);
      run(spi_cmd_pkg::configured_mode, 16'h1880, 16, 1, 0);
      check(err_flag, 1);
      @(posedge core_clk) #2 err_clr = 1'b1;
      @(posedge core_clk) #2 err_clr = 1'b0;
      @(posedge core_clk) #2 check(err_flag, 0);
      run(spi_cmd_pkg::error_mode, 16'h1880, 16, 0, 0);
      run(spi_cmd_pkg::configuration_mode, 16'h1140, 16, 0, 0);
      check(tgt, spi_cmd_pkg::verification_mode);
      run(spi_cmd_pkg::default_mode, 16'h1140, 16, 1, 0);
      run(spi_cmd_pkg::configuration_mode, 16'h1220, 16, 0, 0);
      check(tgt, spi_cmd_pkg::configured_mode);
      run(spi_cmd_pkg::active_mode, 16'h1220, 16, 1, 0);
      run(spi_cmd_pkg::active_mode, 16'h1410, 16, 0, 0);
      @(posedge core_clk) #2 pce = 1'b0;
      run(spi_cmd_pkg::default_mode, 16'h1411, 16, 1, 0);
      run(spi_cmd_pkg::default_mode, mk({4'h0, ra, 6'h15}) ^ 16'h1, 16, 0, 1);
      @(posedge core_clk) #2 pce = 1'b1;
      run(spi_cmd_pkg::default_mode, mk({4'h0, ra, 6'h15}) ^ 16'h1, 16, 1, 0);
      run(spi_cmd_pkg::verification_mode, mk({4'h0, ra, 6'h15}), 16, 0, 1);
      check(n_rd, 2);
      @(posedge core_clk) #2 rd_busy = 1'b1;
      run(spi_cmd_pkg::default_mode, mk({4'h0, ra, 6'h15}), 16, 1, 0);
      @(posedge core_clk) #2 rd_busy = 1'b0;
      run(spi_cmd_pkg::default_mode, mk({4'h0, bad, 6'h15}), 16, 1, 0);
      run(spi_cmd_pkg::configured_mode, mk({7'h22, d[15:8]}), 16, 0, 0);
      check(n_wr, 0);
      run(spi_cmd_pkg::configured_mode, mk({4'ha, ra, d[7:2]}), 16, 0, 0);
      check({wr_req.addr, wr_req.data}, {ra, d[15:2], 2'b00});
      run(spi_cmd_pkg::configured_mode, mk({4'ha, bad, d[7:2]}), 16, 1, 0);
      run(spi_cmd_pkg::configured_mode, mk({4'ha, ra, d[7:2]}), 16, 0, 0);
      check(wr_req.data, {8'h00, d[7:2], 2'b00});
      run(spi_cmd_pkg::default_mode, 16'hfffe, 16, 1, 0);
      run(spi_cmd_pkg::default_mode, 16'h1410, 15, 1, 0);
      run(spi_cmd_pkg::default_mode, {16'h2b5c, 16'h1410}, 32, 0, 0);
      m_u.blip(8);
      check(n_err, 10);
      m_u.blip(100);
      check(n_err, 11);
      @(posedge core_clk) #2 rst = 1'b1;
      repeat (4) @(posedge core_clk);
      #2 rst = 1'b0;
      repeat (5) @(posedge core_clk);
      #2 check(err_flag, 0);
      ans = mk(psr);
      run(spi_cmd_pkg::default_mode, 16'h1410, 16, 0, 0);
      check(n_mode, 4);
      check(n_wr, 2);
      tally_and_finish();
   end
endmodule
